// >>> rtl/frcc_regs.vh
// Register offsets, field positions and edge mode codes of the capture/compare unit
`ifndef FRCC_REGS_VH
`define FRCC_REGS_VH
`define ADDR_CTRL0 5'h00
`define ADDR_CTRL1 5'h01
`define ADDR_COUNT0 5'h02
`define ADDR_COUNT1 5'h03
`define ADDR_CAPCFG 5'h04
`define ADDR_CAP0 5'h05
`define ADDR_CAP1 5'h06
`define ADDR_OUTLVL 5'h07
`define ADDR_STATUS 5'h08
`define ADDR_MASK 5'h09
`define ADDR_XFER 5'h0A
`define ADDR_CMP_BASE 5'h10
`define CTRL_DIV_LSB 0
`define CTRL_CLR_BIT 2
`define CTRL_RUN_BIT 3
`define CTRL_RESET 4'h0
`define ST_OVF0 0
`define ST_OVF1 1
`define ST_CAP0 2
`define ST_CAP1 3
`define ST_CMP_LSB 4
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`endif

// >>> rtl/cmp_reg_bank.v
// Small memory holding the eight compare values, registered read port
`timescale 1ns/100ps
`default_nettype none
module cmp_reg_bank #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i, // Clock
  input wire we_i, // Write strobe
  input wire [AW-1:0] waddr_i, // Write index
  input wire [WIDTH-1:0] wdata_i, // Write data
  input wire [AW-1:0] raddr_i, // Read index
  output reg [WIDTH-1:0] rdata_o, // Registered read data
  output wire [WIDTH*DEPTH-1:0] all_o // Every entry, for the comparators
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  integer k;
  genvar g;
  // Storage starts at zero so comparators see defined values
  initial begin
    for (k = 0; k < DEPTH; k = k + 1) begin
      mem_q[k] = {WIDTH{1'b0}};
    end
  end
  // Write port and registered read port
  always @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
  // Flat view for the parallel comparators
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : flat
      assign all_o[g*WIDTH +: WIDTH] = mem_q[g];
    end
  endgenerate
endmodule // cmp_reg_bank
`default_nettype wire

// >>> rtl/freerun_capture_compare_unit.v
// Two free-running counters with two capture and eight compare channels, Avalon-MM slave
//
// Notes on behaviour
// R1: Counter value is the shared time base for capture and compare channels.
// R2: Counter overflow from FFFF to 0000 can raise an interrupt.
// R3: Counters clear on reset, on clear bit write, on compare match: counter 0 on compare 0-4, counter 1 on compare 4-7.
// R4: Count rate selectable as clock divided by 4, 16, 64 or 256.
// R5: Selected trigger edge stores counter value and raises capture interrupt.
// R6: Both capture channels latch and interrupt independently.
// R7: Capture event may also request an autonomous transfer.
// R8: Per channel choice of rising, falling or both edges.
// R9: Trigger is OR of two pins; system keeps unused pin inactive.
// R10: Compare equality toggles output pin and clears its unit counter.
// R11: Software sets each compare pin starting level after reset.
// R12: All eight compare pins toggle independently.
// R13: Each compare channel has its own interrupt flag.
// R14: Unit 0 holds counter 0, compare 0-3 and both captures.
// R15: Unit 1 holds counter 1 and compare 4 upward, no capture.
// R16: Triggers are synchronised before edge detection, one capture per edge.
`timescale 1ns/100ps
`default_nettype none
`include "frcc_regs.vh"
module freerun_capture_compare_unit #(
  parameter NCMP = 8,
  parameter CW = 16
) (
  input wire CLK_I, // 250 MHz clock
  input wire RESET_N_I, // Synchronous reset, active low
  input wire [4:0] AVS_ADDRESS_I, // Word address
  input wire AVS_READ_I, // Read request
  input wire AVS_WRITE_I, // Write request
  input wire [31:0] AVS_WRITEDATA_I, // Write data
  input wire [3:0] AVS_BYTEENABLE_I, // Byte enables
  output reg [31:0] AVS_READDATA_O, // Read data
  output reg AVS_WAITREQUEST_O, // Wait request
  input wire CAP0_TRIG_A_I, // Capture 0 trigger pin a
  input wire CAP0_TRIG_B_I, // Capture 0 trigger pin b
  input wire CAP1_TRIG_A_I, // Capture 1 trigger pin a
  input wire CAP1_TRIG_B_I, // Capture 1 trigger pin b
  output reg [NCMP-1:0] CMP_OUT_O, // Compare waveform pins
  output reg IRQ_O, // Level interrupt
  output reg [1:0] XFER_REQ_O // Transfer request pulse per capture
);
  localparam ST_W = 4 + NCMP;
  // Bus states, one-hot
  localparam S_IDLE = 3'b001;
  localparam S_READ = 3'b010;
  localparam S_DONE = 3'b100;
  // Prescaler terminal count for the selected division
  function [7:0] div_max;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: div_max = 8'h03;
        2'h1: div_max = 8'h0F;
        2'h2: div_max = 8'h3F;
        default: div_max = 8'hFF;
      endcase
    end
  endfunction
  // Edge qualification by mode
  function edge_hit;
    input [1:0] mode;
    input now;
    input prev;
    begin
      case (mode)
        `EDGE_RISE: edge_hit = now & ~prev;
        `EDGE_FALL: edge_hit = ~now & prev;
        `EDGE_BOTH: edge_hit = now ^ prev;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction
  // Write decode for one register index, only in the completing cycle
  function reg_hit;
    input ok;
    input [4:0] addr;
    input [4:0] idx;
    begin
      reg_hit = ok & (addr == idx);
    end
  endfunction
  // Software-visible control and the two time bases
  reg [3:0] ctrl0_q; // Unit 0 divider and run
  reg [3:0] ctrl1_q; // Unit 1 divider and run
  reg [7:0] pre0_q; // Unit 0 prescaler
  reg [7:0] pre1_q; // Unit 1 prescaler
  reg [CW-1:0] cnt0_q; // Counter 0
  reg [CW-1:0] cnt1_q; // Counter 1
  reg [3:0] capcfg_q;
  reg [1:0] xfer_en_q;
  reg [CW-1:0] cap0_q; // Capture 0 latch
  reg [CW-1:0] cap1_q; // Capture 1 latch
  reg [ST_W-1:0] status_q; // Sticky event flags
  reg [ST_W-1:0] mask_q; // Interrupt enables
  reg [1:0] sync1_q; // First trigger stage
  reg [1:0] sync2_q; // Second trigger stage
  reg [1:0] prev_q; // Edge reference
  reg [2:0] bus_state_q;
  reg [4:0] addr_q;
  reg clr0_req_q; // Delayed clear of counter 0
  reg clr1_req_q; // Delayed clear of counter 1
  // Combinational helpers
  wire [CW*NCMP-1:0] cmp_all;
  wire [CW-1:0] cmp_rdata;
  wire tick0;
  wire tick1;
  wire wr_ok;
  wire cmp_we;
  wire clr0_now;
  wire clr1_now;
  reg [NCMP-1:0] match;
  reg [ST_W-1:0] events;
  reg [ST_W-1:0] w1c_mask;
  reg [1:0] cap_hit;
  reg [31:0] rd_mux;
  reg lvl_we;
  integer i;
  integer j;
  // A write lands only at the edge where the master sees waitrequest low
  assign wr_ok = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
  assign cmp_we = wr_ok & (AVS_ADDRESS_I[4:3] == 2'b10) & (&AVS_BYTEENABLE_I[1:0]);
  // Count enables: one pulse per prescaler period
  assign tick0 = ctrl0_q[`CTRL_RUN_BIT] & (pre0_q == div_max(ctrl0_q[1:0])); // R4
  assign tick1 = ctrl1_q[`CTRL_RUN_BIT] & (pre1_q == div_max(ctrl1_q[1:0])); // R4
  // Clear sources: software strobe, or a match on compare 0 to 4 for counter 0 and on compare 4 to 7 for counter 1
  assign clr0_now = clr0_req_q | (|match[4:0]); // R3
  assign clr1_now = clr1_req_q | (|match[NCMP-1:4]); // R3
  // Read index follows the live bus address, so the bank answers on the same edge that takes the request
  cmp_reg_bank #(.WIDTH(CW), .DEPTH(NCMP), .AW(3)) u_bank (
    .clk_i(CLK_I),
    .we_i(cmp_we),
    .waddr_i(AVS_ADDRESS_I[2:0]),
    .wdata_i(AVS_WRITEDATA_I[CW-1:0]),
    .raddr_i(AVS_ADDRESS_I[2:0]),
    .rdata_o(cmp_rdata),
    .all_o(cmp_all)
  );
  // Match only on a count edge so one equal value toggles once, not every cycle
  always @* begin
    match = {NCMP{1'b0}};
    for (i = 0; i < NCMP; i = i + 1) begin
      if (i < 4) begin
        match[i] = tick0 & (cnt0_q == cmp_all[i*CW +: CW]); // R1 R14
      end else begin
        match[i] = tick1 & (cnt1_q == cmp_all[i*CW +: CW]); // R15
      end
    end
  end
  // Either pin of a pair fires the channel; an idle partner pin is assumed
  always @* begin
    cap_hit[0] = edge_hit(capcfg_q[1:0], sync2_q[0], prev_q[0]); // R8 R9 R16
    cap_hit[1] = edge_hit(capcfg_q[3:2], sync2_q[1], prev_q[1]); // R6 R8 R9
    events = {ST_W{1'b0}};
    events[`ST_OVF0] = tick0 & (&cnt0_q); // R2
    events[`ST_OVF1] = tick1 & (&cnt1_q); // R2
    events[`ST_CAP0] = cap_hit[0]; // R5
    events[`ST_CAP1] = cap_hit[1]; // R5
    events[`ST_CMP_LSB +: NCMP] = match; // R13
  end
  // Two-flop trigger synchroniser, edge detect only on the second stage
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      prev_q <= 2'h0;
    end else begin
      sync1_q <= {CAP1_TRIG_A_I | CAP1_TRIG_B_I, CAP0_TRIG_A_I | CAP0_TRIG_B_I}; // R9
      sync2_q <= sync1_q; // R16
      prev_q <= sync2_q; // R16
    end
  end
  // Prescalers restart whenever their counter is stopped
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      pre0_q <= 8'h00;
      pre1_q <= 8'h00;
    end else begin
      if (!ctrl0_q[`CTRL_RUN_BIT] || tick0) begin
        pre0_q <= 8'h00;
      end else begin
        pre0_q <= pre0_q + 8'h01;
      end
      if (!ctrl1_q[`CTRL_RUN_BIT] || tick1) begin
        pre1_q <= 8'h00;
      end else begin
        pre1_q <= pre1_q + 8'h01;
      end
    end
  end
  // Counters; compare 4 in unit 1 also clears counter 0
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      cnt0_q <= {CW{1'b0}}; // R3
      cnt1_q <= {CW{1'b0}}; // R3
    end else begin
      if (clr0_now) begin
        cnt0_q <= {CW{1'b0}}; // R3 R10
      end else if (tick0) begin
        cnt0_q <= cnt0_q + 1'b1;
      end
      if (clr1_now) begin
        cnt1_q <= {CW{1'b0}}; // R3 R10
      end else if (tick1) begin
        cnt1_q <= cnt1_q + 1'b1;
      end
    end
  end
  // Capture latches and transfer requests
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      cap0_q <= {CW{1'b0}};
      cap1_q <= {CW{1'b0}};
      XFER_REQ_O <= 2'h0;
    end else begin
      if (cap_hit[0]) begin
        cap0_q <= cnt0_q; // R5 R14
      end
      if (cap_hit[1]) begin
        cap1_q <= cnt0_q; // R5 R6
      end
      XFER_REQ_O <= cap_hit & xfer_en_q; // R7
    end
  end
  // Compare pins: software write sets start level, a match toggles that pin alone
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      CMP_OUT_O <= {NCMP{1'b0}};
    end else if (lvl_we) begin
      CMP_OUT_O <= AVS_WRITEDATA_I[NCMP-1:0] ^ match; // R11
    end else begin
      CMP_OUT_O <= CMP_OUT_O ^ match; // R10 R12
    end
  end
  // Clear mask honours byte lanes, so a narrow write leaves the other lane alone
  always @* begin
    w1c_mask = {ST_W{1'b0}};
    if (reg_hit(wr_ok, AVS_ADDRESS_I, `ADDR_STATUS)) begin
      for (j = 0; j < ST_W; j = j + 1) begin
        w1c_mask[j] = AVS_WRITEDATA_I[j] & AVS_BYTEENABLE_I[j / 8];
      end
    end
  end
  // Status: set wins over write-one-to-clear
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      status_q <= {ST_W{1'b0}};
      IRQ_O <= 1'b0;
    end else begin
      status_q <= (status_q & ~w1c_mask) | events; // R2 R5 R13
      IRQ_O <= |((status_q | events) & mask_q);
    end
  end
  // Pin level write strobe
  always @* begin
    lvl_we = reg_hit(wr_ok, AVS_ADDRESS_I, `ADDR_OUTLVL) & AVS_BYTEENABLE_I[0];
  end
  // Register writes; the lane 0 enable alone gates every field but the clear bits, though mask bits 8 to 11 sit in lane 1
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ctrl0_q <= `CTRL_RESET;
      ctrl1_q <= `CTRL_RESET;
      capcfg_q <= 4'h0;
      xfer_en_q <= 2'h0;
      mask_q <= {ST_W{1'b0}};
      clr0_req_q <= 1'b0;
      clr1_req_q <= 1'b0;
    end else begin
      // Clear bit is self-clearing, acts one cycle after the write
      clr0_req_q <= reg_hit(wr_ok, AVS_ADDRESS_I, `ADDR_CTRL0) & AVS_WRITEDATA_I[`CTRL_CLR_BIT]; // R3
      clr1_req_q <= reg_hit(wr_ok, AVS_ADDRESS_I, `ADDR_CTRL1) & AVS_WRITEDATA_I[`CTRL_CLR_BIT]; // R3
      if (wr_ok && AVS_BYTEENABLE_I[0]) begin
        case (AVS_ADDRESS_I)
          `ADDR_CTRL0: ctrl0_q <= AVS_WRITEDATA_I[3:0] & 4'hB; // R4
          `ADDR_CTRL1: ctrl1_q <= AVS_WRITEDATA_I[3:0] & 4'hB; // R4
          `ADDR_CAPCFG: capcfg_q <= AVS_WRITEDATA_I[3:0]; // R8
          `ADDR_XFER: xfer_en_q <= AVS_WRITEDATA_I[1:0]; // R7
          `ADDR_MASK: mask_q <= AVS_WRITEDATA_I[ST_W-1:0];
          default: ;
        endcase
      end
    end
  end
  // Read mux for plain registers
  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr_q)
      `ADDR_CTRL0: rd_mux[3:0] = ctrl0_q;
      `ADDR_CTRL1: rd_mux[3:0] = ctrl1_q;
      `ADDR_COUNT0: rd_mux[CW-1:0] = cnt0_q;
      `ADDR_COUNT1: rd_mux[CW-1:0] = cnt1_q;
      `ADDR_CAPCFG: rd_mux[3:0] = capcfg_q;
      `ADDR_CAP0: rd_mux[CW-1:0] = cap0_q;
      `ADDR_CAP1: rd_mux[CW-1:0] = cap1_q;
      `ADDR_OUTLVL: rd_mux[NCMP-1:0] = CMP_OUT_O;
      `ADDR_STATUS: rd_mux[ST_W-1:0] = status_q;
      `ADDR_MASK: rd_mux[ST_W-1:0] = mask_q;
      `ADDR_XFER: rd_mux[1:0] = xfer_en_q;
      default: begin
        if (addr_q[4:3] == 2'b10) begin
          rd_mux[CW-1:0] = cmp_rdata;
        end
      end
    endcase
  end
  // Bus handshake: writes finish on the second edge, reads take three edges
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      bus_state_q <= S_IDLE;
      addr_q <= 5'h00;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0000_0000;
    end else begin
      case (bus_state_q)
        S_IDLE: begin
          AVS_WAITREQUEST_O <= 1'b1;
          if (AVS_READ_I) begin
            addr_q <= AVS_ADDRESS_I;
            bus_state_q <= S_READ;
          end else if (AVS_WRITE_I) begin
            AVS_WAITREQUEST_O <= 1'b0;
            bus_state_q <= S_DONE;
          end
        end
        S_READ: begin
          // Extra cycle lets the compare bank's registered read settle
          AVS_READDATA_O <= rd_mux;
          AVS_WAITREQUEST_O <= 1'b0;
          bus_state_q <= S_DONE;
        end
        S_DONE: begin
          AVS_WAITREQUEST_O <= 1'b1;
          bus_state_q <= S_IDLE;
        end
        default: begin
          AVS_WAITREQUEST_O <= 1'b1;
          bus_state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // freerun_capture_compare_unit
`default_nettype wire

// >>> sim/frcc_sva.sv
// Port-level assertions for the capture/compare unit
`timescale 1ns/100ps
`default_nettype none
`include "frcc_regs.vh"
module frcc_sva #(
  parameter NCMP = 8
) (
  input wire CLK_I, // Clock
  input wire RESET_N_I, // Reset, active low
  input wire [4:0] AVS_ADDRESS_I, // Word address
  input wire AVS_READ_I, // Read request
  input wire AVS_WRITE_I, // Write request
  input wire [31:0] AVS_READDATA_O, // Read data
  input wire AVS_WAITREQUEST_O, // Wait request
  input wire [NCMP-1:0] CMP_OUT_O, // Compare pins
  input wire IRQ_O, // Interrupt
  input wire [1:0] XFER_REQ_O // Transfer requests
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Read answer comes one cycle later than a write answer
  sequence s_read_ans;
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
  endsequence
  sequence s_irq_clear_write;
    AVS_WRITE_I && (AVS_ADDRESS_I == `ADDR_STATUS || AVS_ADDRESS_I == `ADDR_MASK);
  endsequence
  property p_reset;
    disable iff (1'b0) !RESET_N_I |=> !(|CMP_OUT_O) && !IRQ_O && XFER_REQ_O == 2'h0 && AVS_WAITREQUEST_O;
  endproperty
  property p_wr_ans;
    $rose(AVS_WRITE_I) |=> !AVS_WAITREQUEST_O;
  endproperty
  property p_rd_ans;
    $rose(AVS_READ_I) |=> s_read_ans;
  endproperty
  property p_ack_once;
    $fell(AVS_WAITREQUEST_O) |=> AVS_WAITREQUEST_O;
  endproperty
  property p_ack_cause;
    !AVS_WAITREQUEST_O |-> AVS_READ_I || AVS_WRITE_I;
  endproperty
  property p_rd_hold;
    !AVS_READ_I |=> $stable(AVS_READDATA_O);
  endproperty
  property p_xfer0;
    XFER_REQ_O[0] |=> !XFER_REQ_O[0];
  endproperty
  property p_xfer1;
    XFER_REQ_O[1] |=> !XFER_REQ_O[1];
  endproperty
  // Interrupt only drops after software touched status or mask
  property p_irq_fall;
    $fell(IRQ_O) |-> $past(AVS_WRITE_I, 2) && ($past(AVS_ADDRESS_I, 2) == `ADDR_STATUS || $past(AVS_ADDRESS_I, 2) == `ADDR_MASK);
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not idle in reset");
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  a_rd_ans: assert property (p_rd_ans) else $error("read answer timing wrong");
  a_ack_once: assert property (p_ack_once) else $error("waitrequest low too long");
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
  a_xfer0: assert property (p_xfer0) else $error("transfer request 0 too long");
  a_xfer1: assert property (p_xfer1) else $error("transfer request 1 too long");
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without cause");
  c_clear: cover property (s_irq_clear_write);
endmodule // frcc_sva
bind freerun_capture_compare_unit frcc_sva #(.NCMP(NCMP)) i_frcc_sva (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
  .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .CMP_OUT_O(CMP_OUT_O),
  .IRQ_O(IRQ_O), .XFER_REQ_O(XFER_REQ_O));
`default_nettype wire

// >>> sim/trigger_pins_model.sv
// External trigger drivers for both capture channels
`timescale 1ns/100ps
`default_nettype none
module trigger_pins_model (
  input wire logic [1:0] level_i, // Wanted trigger level per channel
  input wire logic [1:0] use_b_i, // Drive pin b instead of pin a
  output wire logic [1:0] pin_a_o, // Pin a per channel
  output wire logic [1:0] pin_b_o // Pin b per channel
);
  // Unused pin of a pair stays low, as the unit cannot mask one pin alone
  assign pin_a_o = level_i & ~use_b_i;
  assign pin_b_o = level_i & use_b_i;
endmodule // trigger_pins_model
`default_nettype wire

// >>> sim/freerun_capture_compare_unit_tb.sv
// Self-checking bench for the capture/compare unit
`timescale 1ns/100ps
`default_nettype none
`include "frcc_regs.vh"
module freerun_capture_compare_unit_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [1:0] lvl = 2'h0;
  logic [1:0] use_b = 2'h0;
  logic [31:0] got;
  logic [31:0] cnt;
  logic [1:0] xfer_seen = 2'h0;
  logic xfer_clr = 1'b0;
  logic w;
  wire logic [1:0] pin_a;
  wire logic [1:0] pin_b;
  wire logic [31:0] rdata;
  wire logic waitreq;
  wire logic [7:0] cmp_out;
  wire logic irq;
  wire logic [1:0] xfer;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  int k;
  // Register rows: address, write value, value read back
  logic [4:0] ra [7] = '{`ADDR_CAPCFG, `ADDR_MASK, `ADDR_XFER, 5'h17, `ADDR_CTRL1, 5'h1F, `ADDR_COUNT1};
  logic [31:0] rw [7] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFABCD, 32'h7, 32'h5A, 32'hFFFF};
  logic [31:0] re [7] = '{32'hF, 32'hFFF, 32'h3, 32'hABCD, 32'h3, 32'h0, 32'h0};
  freerun_capture_compare_unit i_freerun_capture_compare_unit (.CLK_I(clk), .RESET_N_I(rst_n),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .CAP0_TRIG_A_I(pin_a[0]), .CAP0_TRIG_B_I(pin_b[0]), .CAP1_TRIG_A_I(pin_a[1]),
    .CAP1_TRIG_B_I(pin_b[1]), .CMP_OUT_O(cmp_out), .IRQ_O(irq), .XFER_REQ_O(xfer));
  trigger_pins_model i_trigger_pins_model (.level_i(lvl), .use_b_i(use_b), .pin_a_o(pin_a), .pin_b_o(pin_b));
  always #2 clk = ~clk;
  // Cycle ceiling cuts a hang short; one-cycle transfer pulses are kept sticky
  always @(posedge clk) begin
    cycles <= cycles + 1;
    xfer_seen <= xfer_clr ? 2'h0 : (xfer_seen | xfer);
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  task print_verdict;
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task check(input string what, input logic [31:0] exp, input logic [31:0] act);
    num_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, act);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then releases it
  task bus(input logic wn, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= wn;
    rd <= !wn;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    check("pins", 32'h0, {24'h0, cmp_out});
    bus(0, `ADDR_COUNT0, 0);
    check("count0", 32'h0, got);
    for (n = 0; n < 7; n++) begin
      bus(1, ra[n], rw[n]);
      bus(0, ra[n], 0);
      check("reg", re[n], got);
    end
    // Compare values far away so the counters run freely
    for (n = 0; n < 8; n++) bus(1, 5'(`ADDR_CMP_BASE + n), 32'hFFFF);
    bus(1, `ADDR_CTRL0, 32'h8);
    repeat (40) @(posedge clk);
    bus(1, `ADDR_CTRL0, 32'h0);
    bus(0, `ADDR_COUNT0, 0);
    cnt = got;
    check("count0 ran", 32'h1, {31'h0, cnt != 0});
    bus(1, `ADDR_CAPCFG, 32'h9);
    bus(1, `ADDR_STATUS, 32'hFFF);
    xfer_clr <= 1'b1;
    lvl <= 2'b01;
    @(posedge clk);
    xfer_clr <= 1'b0;
    repeat (7) @(posedge clk);
    bus(0, `ADDR_CAP0, 0);
    check("cap0", cnt, got);
    bus(0, `ADDR_STATUS, 0);
    check("status", 32'h4, got);
    check("xfer", 32'h1, {30'h0, xfer_seen});
    check("irq", 32'h1, {31'h0, irq});
    use_b <= 2'b10;
    lvl <= 2'b11;
    repeat (8) @(posedge clk);
    lvl <= 2'b01;
    repeat (8) @(posedge clk);
    bus(0, `ADDR_CAP1, 0);
    check("cap1", cnt, got);
    bus(0, `ADDR_STATUS, 0);
    check("status", 32'hC, got);
    bus(1, `ADDR_MASK, 32'h0);
    repeat (2) @(posedge clk);
    check("irq masked", 32'h0, {31'h0, irq});
    lvl <= 2'b00;
    // Every edge mode on channel 0, rising then falling
    for (n = 0; n < 4; n++) begin
      bus(1, `ADDR_CAPCFG, n);
      for (k = 0; k < 2; k++) begin
        bus(1, `ADDR_STATUS, 32'hFFF);
        lvl[0] <= (k == 0);
        repeat (8) @(posedge clk);
        bus(0, `ADDR_STATUS, 0);
        check("edge mode", ((n >> k) & 1) << 2, got & 32'h4);
      end
    end
    bus(1, `ADDR_CMP_BASE, 32'h1);
    bus(1, `ADDR_CTRL0, 32'h4);
    bus(1, `ADDR_STATUS, 32'hFFF);
    // Toggle period of compare 0 at value 1 for every divider
    for (n = 0; n < 4; n++) begin
      bus(1, `ADDR_CTRL0, 32'h8 | n);
      w = cmp_out[0];
      while (cmp_out[0] === w) @(posedge clk);
      k = 0;
      w = cmp_out[0];
      while (cmp_out[0] === w) begin
        @(posedge clk);
        k++;
      end
      check("period", 8 << (2 * n), k);
    end
    check("other pins", 32'h0, {25'h0, cmp_out[7:1]});
    bus(0, `ADDR_STATUS, 0);
    check("cmp status", 32'h10, got);
    bus(1, `ADDR_CTRL0, 32'h0);
    bus(1, `ADDR_OUTLVL, 32'hA5);
    @(posedge clk);
    check("outlvl", 32'hA5, {24'h0, cmp_out});
    // Compare 4 at value 1 on counter 1, which also clears counter 0
    bus(1, 5'(`ADDR_CMP_BASE + 4), 32'h1);
    bus(1, `ADDR_CTRL1, 32'h8);
    w = cmp_out[4];
    while (cmp_out[4] === w) @(posedge clk);
    k = 0;
    w = cmp_out[4];
    while (cmp_out[4] === w) begin
      @(posedge clk);
      k++;
    end
    check("period unit1", 32'h8, k);
    check("unit1 other pins", 32'h5, {28'h0, cmp_out[3:0]});
    bus(0, `ADDR_COUNT0, 0);
    check("count0 cleared by cmp4", 32'h0, got);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check("pins in reset", 32'h0, {24'h0, cmp_out});
    rst_n <= 1'b1;
    bus(0, `ADDR_CTRL1, 0);
    check("ctrl1 after reset", 32'h0, got);
    bus(0, `ADDR_COUNT1, 0);
    check("count1 after reset", 32'h0, got);
    print_verdict();
  end
endmodule // freerun_capture_compare_unit_tb
`default_nettype wire
